/* File: inc/pattern_run_pkg.sv */
// constants, register map and types for the pattern run frequency sequencer
package pattern_run_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_MS     = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam logic [6:0]  CENTER_MAX = 7'h78;      // 120 Hz
  localparam logic [4:0]  WIDTH_MAX  = 5'h1e;      // 30 Hz
  localparam logic [13:0] FREQ_MAX   = 14'h2ee0;   // 120.00 Hz in 0.01 Hz
  localparam logic [14:0] HZ_SCALE   = 15'h0064;   // 1 Hz in 0.01 Hz units
  localparam logic [3:0]  FSEL_PATTERN = 4'ha;

  localparam logic [1:0] MODE_ONCE_STOP = 2'h0;
  localparam logic [1:0] MODE_REPEAT    = 2'h1;
  localparam logic [1:0] MODE_ONCE_HOLD = 2'h2;

  localparam logic [7:0] OFF_FSEL     = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_CENTER_A = 8'h08;
  localparam logic [7:0] OFF_CENTER_B = 8'h0c;
  localparam logic [7:0] OFF_CENTER_C = 8'h10;
  localparam logic [7:0] OFF_WIDTH    = 8'h14;
  localparam logic [7:0] OFF_ASSIGN   = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1c;
  localparam logic [7:0] OFF_SETFREQ  = 8'h20;
  localparam logic [1:0] PRESET_PAGE  = 2'h1;      // 0x44..0x7c
  localparam logic [2:0] STAGE_PAGE   = 3'h4;      // 0x80..0x98

  localparam int unsigned DUR_EXP_LSB  = 10;
  localparam int unsigned STG_DIR_BIT  = 12;
  localparam int unsigned STG_RAMP_LSB = 13;
  localparam logic [9:0] MANT_MAX     = 10'h3e7;   // 999
  localparam logic [9:0] MANT_MAX_X10 = 10'h258;   // 600 x 10 s

  localparam logic [3:0]  FSEL_RST   = 4'h0;
  localparam logic [1:0]  MODE_RST   = 2'h0;
  localparam logic [3:0]  ASSIGN_RST = 4'hf;
  localparam logic [2:0]  LAST_STAGE = 3'h6;

  typedef enum logic [1:0] {ST_STOPPED, ST_RUNNING, ST_ENDED} seq_state_type;
endpackage : pattern_run_pkg

/* File: src/pattern_run_freq_sequencer.sv */
// jump band avoider, multistep selector and seven-stage pattern sequencer
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - three avoidance centres; a centre of zero disables that band
// - centres span 0..120 Hz in 1 Hz steps
// - one shared band width, 0..30 Hz in 1 Hz steps
// - accelerating into a band holds set frequency at its lower edge
// - request above upper edge passes through unchanged
// - decelerating into a band holds set frequency at its upper edge
// - overlapping or adjoining bands merge into one band
// - four weighted step inputs pick one of fifteen presets
// - unassigned step inputs count as off
// - presets span 0..120.00 Hz in 0.01 Hz steps
// - mode 0 one cycle then stop, 1 repeat, 2 one cycle then hold
// - pattern runs only with frequency source ten
// - seven stages in order, stage n targets preset n
// - stage time 0..6000 s held as three significant digits
// - zero stage time skips the stage
// - each stage carries its own rotation direction
// - each stage picks one of four ramp pairs
// - stop pauses stage advance, forward run resumes it
// - stop then reset returns the sequence to stage one
// - after alarm, reset clears it and run resumes advance
// - reverse commands ignored while pattern runs, no self hold
// - stopping cycle end ramps down with the first ramp pair
module pattern_run_freq_sequencer #(
  parameter int unsigned TICK_CYCLES = pattern_run_pkg::TICK_CYCLES
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_forward_run_cmd,
  input  wire logic        i_reverse_run_cmd,
  input  wire logic        i_stop_cmd,
  input  wire logic        i_reset_cmd,
  input  wire logic        i_alarm_stop,
  input  wire logic        i_step_sel_w1,
  input  wire logic        i_step_sel_w2,
  input  wire logic        i_step_sel_w4,
  input  wire logic        i_step_sel_w8,
  input  wire logic [13:0] i_base_freq,
  output logic [13:0]      o_set_freq,
  output logic             o_run,
  output logic             o_dir_reverse,
  output logic [1:0]       o_ramp_sel,
  output logic [2:0]       o_stage
);
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      old_v[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
    return old_v;
  endfunction : merge_be

  // three significant digits: mantissa 0..999 with a decade exponent, capped at 6000 s
  function automatic logic [11:0] dur_clamp(input logic [11:0] v);
    logic [9:0] m;
    m = (v[9:0] > pattern_run_pkg::MANT_MAX) ? pattern_run_pkg::MANT_MAX : v[9:0];
    if (v[11:10] == 2'h3 && m > pattern_run_pkg::MANT_MAX_X10) m = pattern_run_pkg::MANT_MAX_X10;
    return {v[11:10], m};
  endfunction : dur_clamp

  // duration in 10 ms ticks
  function automatic logic [19:0] dur_ticks(input logic [11:0] v);
    logic [19:0] m;
    m = {10'h000, v[9:0]};
    unique case (v[11:10])
      2'h0: return m;
      2'h1: return 20'(m * 20'h0_000a);
      2'h2: return 20'(m * 20'h0_0064);
      2'h3: return 20'(m * 20'h0_03e8);
    endcase
  endfunction : dur_ticks

  function automatic logic [14:0] edge_lo(input logic [6:0] c, input logic [4:0] w);
    return (c > {2'h0, w}) ? 15'(15'(c - {2'h0, w}) * pattern_run_pkg::HZ_SCALE) : 15'h0000;
  endfunction : edge_lo

  function automatic logic [14:0] edge_hi(input logic [6:0] c, input logic [4:0] w);
    return 15'(15'({1'b0, c} + {3'h0, w}) * pattern_run_pkg::HZ_SCALE);
  endfunction : edge_hi

  // ---------------- bus slave ----------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [3:0]  fsel_q;
  logic [1:0]  mode_q;
  logic [6:0]  center_q [3];
  logic [4:0]  width_q;
  logic [3:0]  assign_q;
  logic [13:0] preset_q [1:15];
  logic [14:0] stage_cfg_q [7];

  wire        wr_take    = i_avs_write & ~wait_q;
  wire [5:0]  word_addr  = i_avs_address[7:2];
  wire        sel_preset = word_addr[5:4] == pattern_run_pkg::PRESET_PAGE && word_addr[3:0] != 4'h0;
  wire        sel_stage  = word_addr[5:3] == pattern_run_pkg::STAGE_PAGE && word_addr[2:0] != 3'h7;
  wire [3:0]  preset_idx = word_addr[3:0];
  wire [2:0]  stage_idx  = word_addr[2:0];
  wire [31:0] wval       = merge_be(32'h0000_0000, i_avs_writedata, i_avs_byteenable);

  // one wait cycle per access: the answer is ready at the edge where waitrequest is low
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= ~((i_avs_read | i_avs_write) & wait_q);
      if (i_avs_read & wait_q) rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      fsel_q   <= pattern_run_pkg::FSEL_RST;
      mode_q   <= pattern_run_pkg::MODE_RST;
      width_q  <= 5'h00;
      assign_q <= pattern_run_pkg::ASSIGN_RST;
      for (int i = 0; i < 3; i++) center_q[i] <= 7'h00;
      for (int i = 1; i < 16; i++) preset_q[i] <= 14'h0000;
      for (int i = 0; i < 7; i++) stage_cfg_q[i] <= 15'h0000;
    end else if (wr_take) begin
      unique case (i_avs_address)
        pattern_run_pkg::OFF_FSEL:   fsel_q <= wval[3:0];
        pattern_run_pkg::OFF_MODE:   mode_q <= wval[1:0];
        pattern_run_pkg::OFF_CENTER_A,
        pattern_run_pkg::OFF_CENTER_B,
        pattern_run_pkg::OFF_CENTER_C:
          center_q[word_addr[1:0] - 2'h2] <= (wval[6:0] > pattern_run_pkg::CENTER_MAX) ?
                                   pattern_run_pkg::CENTER_MAX : wval[6:0];
        pattern_run_pkg::OFF_WIDTH:
          width_q <= (wval[4:0] > pattern_run_pkg::WIDTH_MAX) ?
                     pattern_run_pkg::WIDTH_MAX : wval[4:0];
        pattern_run_pkg::OFF_ASSIGN: assign_q <= wval[3:0];
        default: begin
          if (sel_preset) preset_q[preset_idx] <= (wval[13:0] > pattern_run_pkg::FREQ_MAX) ?
                                      pattern_run_pkg::FREQ_MAX : wval[13:0];
          if (sel_stage) stage_cfg_q[stage_idx] <= {wval[14:12], dur_clamp(wval[11:0])};
        end
      endcase
    end
  end

  // ---------------- terminal inputs ----------------
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {i_alarm_stop, i_reset_cmd, i_stop_cmd, i_reverse_run_cmd, i_forward_run_cmd,
                  i_step_sel_w8, i_step_sel_w4, i_step_sel_w2, i_step_sel_w1};
      sync2_q <= sync1_q;
    end
  end
  wire       fwd_s    = sync2_q[4];
  wire       rev_s    = sync2_q[5];
  wire       stop_s   = sync2_q[6];
  wire       rst_s    = sync2_q[7];
  wire       alarm_s  = sync2_q[8];
  wire [3:0] step_idx = sync2_q[3:0] & assign_q;

  // ---------------- sequencer ----------------
  pattern_run_pkg::seq_state_type st_q, st_d;
  logic [2:0]  stage_q, stage_d;
  logic [19:0] timer_q, timer_d;
  logic [31:0] presc_q;
  logic        alarm_q;
  logic        rst_prev_q;
  // edge only: a reset held past the alarm clear must not also rewind the stage
  wire         rst_rise    = rst_s & ~rst_prev_q;

  wire        tick        = presc_q == TICK_CYCLES - 1;
  wire        pattern_sel = fsel_q == pattern_run_pkg::FSEL_PATTERN;
  // level run: self-holding is off in pattern mode, the switch must stay closed
  wire        run_ok      = fwd_s & ~stop_s & ~alarm_q;
  wire [14:0] cur_cfg     = stage_cfg_q[stage_q];
  wire        stage_done  = timer_q >= dur_ticks(cur_cfg[11:0]);
  wire        hold_mode   = mode_q == pattern_run_pkg::MODE_ONCE_HOLD;
  wire        end_stop    = st_q == pattern_run_pkg::ST_ENDED && !hold_mode;

  always_comb begin
    st_d    = st_q;
    stage_d = stage_q;
    timer_d = timer_q;
    if (!pattern_sel) begin
      st_d = pattern_run_pkg::ST_STOPPED;
    end else begin
      unique case (st_q)
        pattern_run_pkg::ST_STOPPED: begin
          if (rst_rise && !alarm_q) begin
            stage_d = 3'h0;
            timer_d = 20'h0_0000;
          end else if (run_ok) begin
            st_d = pattern_run_pkg::ST_RUNNING;
          end
        end
        pattern_run_pkg::ST_RUNNING: begin
          if (!run_ok) begin
            st_d = pattern_run_pkg::ST_STOPPED;
          end else if (stage_done) begin
            timer_d = 20'h0_0000;
            if (stage_q != pattern_run_pkg::LAST_STAGE) stage_d = stage_q + 3'h1;
            else if (mode_q == pattern_run_pkg::MODE_REPEAT) stage_d = 3'h0;
            else st_d = pattern_run_pkg::ST_ENDED;
          end else if (tick) begin
            timer_d = timer_q + 20'h0_0001;
          end
        end
        pattern_run_pkg::ST_ENDED: begin
          if (rst_s && !run_ok) begin
            st_d    = pattern_run_pkg::ST_STOPPED;
            stage_d = 3'h0;
            timer_d = 20'h0_0000;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_q    <= pattern_run_pkg::ST_STOPPED;
      stage_q <= 3'h0;
      timer_q <= 20'h0_0000;
      presc_q <= 32'h0000_0000;
      alarm_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end else begin
      rst_prev_q <= rst_s;
      st_q    <= st_d;
      stage_q <= stage_d;
      timer_q <= timer_d;
      presc_q <= tick ? 32'h0000_0000 : presc_q + 32'h0000_0001;
      // a new alarm wins over a reset in the same cycle
      alarm_q <= alarm_s | (alarm_q & ~rst_s);
    end
  end

  // ---------------- request and band avoidance ----------------
  wire [13:0] req_freq = !pattern_sel ? ((step_idx == 4'h0) ? i_base_freq : preset_q[step_idx]) :
                         end_stop ? 14'h0000 :
                         preset_q[{1'b0, stage_q} + 4'h1];
  wire        run_d    = pattern_sel ? (st_q == pattern_run_pkg::ST_RUNNING ||
                                        (st_q == pattern_run_pkg::ST_ENDED && hold_mode && run_ok)) :
                         (fwd_s | rev_s) & ~stop_s & ~alarm_q;
  wire        dir_d    = pattern_sel ? cur_cfg[pattern_run_pkg::STG_DIR_BIT] :
                         rev_s & ~fwd_s;
  wire [1:0]  ramp_d   = (pattern_sel && !end_stop) ?
                         cur_cfg[pattern_run_pkg::STG_RAMP_LSB +: 2] : 2'h0;

  logic [14:0] lo [3];
  logic [14:0] hi [3];
  logic [2:0]  act;
  logic [14:0] band_lo;
  logic [14:0] band_hi;
  logic        in_band;
  logic [13:0] set_q;
  logic [13:0] set_d;

  always_comb begin
    band_lo = 15'h7fff;
    band_hi = 15'h0000;
    in_band = 1'b0;
    for (int i = 0; i < 3; i++) begin
      act[i] = center_q[i] != 7'h00;
      lo[i]  = edge_lo(center_q[i], width_q);
      hi[i]  = edge_hi(center_q[i], width_q);
      if (act[i] && {1'b0, req_freq} >= lo[i] && {1'b0, req_freq} <= hi[i]) begin
        in_band = 1'b1;
        band_lo = (lo[i] < band_lo) ? lo[i] : band_lo;
        band_hi = (hi[i] > band_hi) ? hi[i] : band_hi;
      end
    end
    // two passes reach any chain of three touching bands
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 3; i++) begin
        if (in_band && act[i] && lo[i] <= band_hi && hi[i] >= band_lo) begin
          band_lo = (lo[i] < band_lo) ? lo[i] : band_lo;
          band_hi = (hi[i] > band_hi) ? hi[i] : band_hi;
        end
      end
    end
  end

  assign set_d = !in_band ? req_freq :
                 (req_freq >= set_q) ? band_lo[13:0] :
                 band_hi[13:0];

  logic       run_q;
  logic       dir_q;
  logic [1:0] ramp_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      set_q  <= 14'h0000;
      run_q  <= 1'b0;
      dir_q  <= 1'b0;
      ramp_q <= 2'h0;
    end else begin
      set_q  <= set_d;
      run_q  <= run_d;
      dir_q  <= dir_d;
      ramp_q <= ramp_d;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_avs_address)
      pattern_run_pkg::OFF_FSEL:     rd_mux[3:0] = fsel_q;
      pattern_run_pkg::OFF_MODE:     rd_mux[1:0] = mode_q;
      pattern_run_pkg::OFF_CENTER_A: rd_mux[6:0] = center_q[0];
      pattern_run_pkg::OFF_CENTER_B: rd_mux[6:0] = center_q[1];
      pattern_run_pkg::OFF_CENTER_C: rd_mux[6:0] = center_q[2];
      pattern_run_pkg::OFF_WIDTH:    rd_mux[4:0] = width_q;
      pattern_run_pkg::OFF_ASSIGN:   rd_mux[3:0] = assign_q;
      pattern_run_pkg::OFF_STATUS:   rd_mux[9:0] = {run_q, ramp_q, dir_q, alarm_q, st_q, stage_q};
      pattern_run_pkg::OFF_SETFREQ:  rd_mux[13:0] = set_q;
      default: begin
        if (sel_preset) rd_mux[13:0] = preset_q[preset_idx];
        if (sel_stage) rd_mux[14:0] = stage_cfg_q[stage_idx];
      end
    endcase
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_set_freq        = set_q;
  assign o_run             = run_q;
  assign o_dir_reverse     = dir_q;
  assign o_ramp_sel        = ramp_q;
  assign o_stage           = stage_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence s_paused_clean;
    st_q == pattern_run_pkg::ST_STOPPED && !alarm_q && pattern_sel;
  endsequence
  sequence s_reset_seen;
    rst_rise ##1 stage_q == 3'h0;
  endsequence

  a_band_off_pass: assert property (act == 3'h0 |=> set_q == $past(req_freq))
    else $error("disabled bands altered the set frequency");
  a_center_limit: assert property (center_q[0] <= 7'h78 && center_q[1] <= 7'h78)
    else $error("centre above 120 Hz");
  a_width_limit: assert property (width_q <= 5'h1e)
    else $error("band width above 30 Hz");
  a_hold_lower: assert property (in_band && req_freq >= set_q |=> set_q == $past(band_lo[13:0]))
    else $error("set frequency not held at lower edge");
  a_pass_through: assert property (!in_band |=> set_q == $past(req_freq))
    else $error("request outside bands not passed through");
  a_hold_upper: assert property (in_band && req_freq < set_q |=> set_q == $past(band_hi[13:0]))
    else $error("set frequency not held at upper edge");
  a_merge_cover: assert property (in_band |-> band_lo <= {1'b0, req_freq} && band_hi >= {1'b0, req_freq}
                                  && (band_lo == 15'h0000 ||
                                      band_hi - band_lo >= 15'({width_q, 1'b0}) * pattern_run_pkg::HZ_SCALE))
    else $error("merged band does not span the request");
  a_step_pick: assert property (!pattern_sel && step_idx != 4'h0 |-> req_freq == preset_q[step_idx])
    else $error("wrong preset for step inputs");
  a_skip_zero: assert property (st_q == pattern_run_pkg::ST_RUNNING && run_ok && pattern_sel &&
                                cur_cfg[11:0] == 12'h000 && stage_q < 3'h6
                                |=> stage_q == $past(stage_q) + 3'h1)
    else $error("zero time stage not skipped");
  a_pause_freeze: assert property (s_paused_clean and !rst_s |=> $stable(timer_q))
    else $error("stage timer moved while paused");
  a_restart_one: assert property (s_paused_clean ##0 rst_rise |-> s_reset_seen)
    else $error("reset did not return to stage one");
  a_alarm_block: assert property (alarm_q && pattern_sel |=> st_q != pattern_run_pkg::ST_RUNNING)
    else $error("stage advance during alarm");
  a_rev_ignored: assert property (pattern_sel && rev_s |=> dir_q == $past(cur_cfg[12]))
    else $error("reverse command changed pattern direction");
  a_end_ramp: assert property (pattern_sel && end_stop |=> ramp_q == 2'h0 && set_q <= $past(set_q))
    else $error("cycle end not on first ramp pair");
endmodule : pattern_run_freq_sequencer

`default_nettype wire

/* File: testbench/tb_pattern_run_freq_sequencer.sv */
// bench for the band avoider, multistep selector and pattern sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_pattern_run_freq_sequencer;
  localparam int unsigned TICKS = 4;
  localparam int unsigned DUR   = 20;
  localparam int          LIMIT = 20000;
  logic        i_clk_sys = 1'b0;
  logic        i_srst    = 1'b1;
  logic [7:0]  adr       = '0;
  logic        rd_en     = 1'b0;
  logic        wr_en     = 1'b0;
  logic [31:0] wdata     = '0;
  logic [13:0] base      = '0;
  logic        run_key = 1'b0, back_key = 1'b0, stp = 1'b0, rst = 1'b0, flt = 1'b0;
  logic [3:0]  keys      = '0;
  logic [31:0] rdata;
  logic        waitreq, run, dir, c_run, c_back, c_stop, c_rst, c_alm;
  logic [3:0]  c_step;
  logic [13:0] set_freq;
  logic [1:0]  ramp;
  logic [2:0]  stage;
  logic [13:0] preset [16];
  int          rtab [4] = '{3, 2, 0, 1};
  int          fail_count = 0, samples_checked = 0, cycles = 0, seed = 64;
  int          run2_cnt = 0, skip_cnt = 0, cur = 0, lo = 0, hi = 0;

  term_panel_model partner (.i_clk_sys(i_clk_sys), .i_run_key(run_key), .i_back_key(back_key),
    .i_stop_key(stp), .i_reset_key(rst), .i_fault(flt), .i_step_keys(keys),
    .o_forward_run_cmd(c_run), .o_reverse_run_cmd(c_back), .o_stop_cmd(c_stop),
    .o_reset_cmd(c_rst), .o_alarm_stop(c_alm), .o_step_sel(c_step));

  pattern_run_freq_sequencer #(.TICK_CYCLES(TICKS)) DUT (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_forward_run_cmd(c_run), .i_reverse_run_cmd(c_back), .i_stop_cmd(c_stop),
    .i_reset_cmd(c_rst), .i_alarm_stop(c_alm), .i_step_sel_w1(c_step[0]),
    .i_step_sel_w2(c_step[1]), .i_step_sel_w4(c_step[2]), .i_step_sel_w8(c_step[3]),
    .i_base_freq(base), .o_set_freq(set_freq), .o_run(run), .o_dir_reverse(dir),
    .o_ramp_sel(ramp), .o_stage(stage));

  always #10 i_clk_sys = ~i_clk_sys;

  // time spent running in stage three, and in the skipped stage two
  always @(negedge i_clk_sys) begin
    if (run === 1'b1 && stage === 3'h2) run2_cnt++;
    if (stage === 3'h1) skip_cnt++;
  end

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles >= LIMIT) begin
      fail_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] stg(input int m, input int e, input int d, input int r);
    return 32'(m) | (32'(e) << pattern_run_pkg::DUR_EXP_LSB)
         | (32'(d) << pattern_run_pkg::STG_DIR_BIT) | (32'(r) << pattern_run_pkg::STG_RAMP_LSB);
  endfunction : stg

  // rising requests stop at the low edge, falling ones at the high edge
  function automatic int band_exp(input int req, input int now, input int l, input int h);
    if (req > l && req < h) return (req >= now) ? l : h;
    return req;
  endfunction : band_exp

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // request stands until a rising edge samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_clk_sys);
    adr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= ~w;
    do @(posedge i_clk_sys); while (waitreq !== 1'b0);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : cyc

  task automatic keys_to(input logic r, input logic b, input logic s, input logic z,
                         input logic f);
    @(posedge i_clk_sys);
    run_key <= r;
    back_key <= b;
    stp <= s;
    rst <= z;
    flt <= f;
  endtask : keys_to

  task automatic wait_stage(input logic [2:0] s);
    while (stage !== s) @(negedge i_clk_sys);
  endtask : wait_stage

  task automatic reset_pulse();
    keys_to(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    cyc(6);
    keys_to(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(6);
  endtask : reset_pulse

  task automatic band_step(input int req);
    int e;
    e = band_exp(req, cur, lo, hi);
    @(posedge i_clk_sys);
    base <= 14'(req);
    cyc(4);
    check("set_freq band", set_freq, 32'(e));
    cur = e;
  endtask : band_step

  initial begin
    logic [31:0] q;
    int          i;
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    cyc(1);
    check("waitrequest", waitreq, 32'h0000_0001);
    check("set_freq", set_freq, 32'h0000_0000);
    rd(pattern_run_pkg::OFF_ASSIGN, q);
    check("assign mask", q, 32'h0000_000f);
    wr(pattern_run_pkg::OFF_CENTER_A, 32'h0000_00ff);
    rd(pattern_run_pkg::OFF_CENTER_A, q);
    check("centre clamp", q, 32'(pattern_run_pkg::CENTER_MAX));
    wr(pattern_run_pkg::OFF_WIDTH, 32'h0000_001f);
    rd(pattern_run_pkg::OFF_WIDTH, q);
    check("width clamp", q, 32'(pattern_run_pkg::WIDTH_MAX));
    wr(8'h44, 32'h0000_3fff);
    rd(8'h44, q);
    check("preset clamp", q, 32'(pattern_run_pkg::FREQ_MAX));
    wr(8'h80, stg(1023, 0, 0, 0));
    rd(8'h80, q);
    check("stage digits", q, stg(999, 0, 0, 0));
    wr(8'h84, stg(700, 3, 0, 0));
    rd(8'h84, q);
    check("stage ceiling", q, stg(600, 3, 0, 0));
    rd(8'hfc, q);
    check("unmapped", q, 32'h0000_0000);
    preset[0] = '0;
    for (i = 1; i < 16; i++) preset[i] = 14'($unsigned($random(seed)) % 12001);
    preset[15] = pattern_run_pkg::FREQ_MAX;
    for (i = 1; i < 16; i++) wr(8'(8'h40 + 4 * i), 32'(preset[i]));
    wr(pattern_run_pkg::OFF_CENTER_A, 32'h0000_0000);
    wr(pattern_run_pkg::OFF_WIDTH, 32'h0000_0002);
    for (i = 0; i < 16; i++) begin
      @(posedge i_clk_sys);
      keys <= 4'(i);
      base <= 14'($unsigned($random(seed)) % 12001);
      cyc(6);
      check("multistep", set_freq, 32'((i == 0) ? base : preset[i]));
    end
    wr(pattern_run_pkg::OFF_ASSIGN, 32'h0000_0001);
    cyc(6);
    check("unassigned off", set_freq, 32'(preset[1]));
    wr(pattern_run_pkg::OFF_ASSIGN, 32'h0000_000f);
    @(posedge i_clk_sys);
    keys <= 4'h0;
    band_step(0);
    wr(pattern_run_pkg::OFF_CENTER_A, 32'h0000_0014);
    lo = 1800;
    hi = 2200;
    band_step(2000);
    band_step(2500);
    band_step(2100);
    band_step(1500);
    wr(pattern_run_pkg::OFF_CENTER_B, 32'h0000_0018);
    hi = 2600;
    band_step(2400);
    band_step(2700);
    band_step(2300);
    wr(pattern_run_pkg::OFF_CENTER_A, 32'h0000_0000);
    wr(pattern_run_pkg::OFF_CENTER_B, 32'h0000_0000);
    lo = 0;
    hi = 0;
    band_step(2000);
    for (i = 0; i < 7; i++) wr(8'(8'h80 + 4 * i), (i % 2) ? 32'h0 : stg(DUR, 0, (i / 2) % 2, rtab[i / 2]));
    wr(pattern_run_pkg::OFF_MODE, 32'h0000_0000);
    wr(pattern_run_pkg::OFF_FSEL, 32'(pattern_run_pkg::FSEL_PATTERN));
    run2_cnt = 0;
    skip_cnt = 0;
    keys_to(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    for (i = 0; i < 4; i++) begin
      wait_stage(3'(2 * i));
      cyc(8);
      check("stage dir", dir, 32'(i % 2));
      check("stage ramp", ramp, 32'(rtab[i]));
      check("stage freq", set_freq, 32'(preset[2 * i + 1]));
      if (i == 1) begin
        cyc(30);
        keys_to(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        cyc(100);
        check("paused stage", stage, 32'h0000_0002);
        check("paused run", run, 32'h0000_0000);
        keys_to(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      end
    end
    while (run !== 1'b0) @(negedge i_clk_sys);
    check("end freq", set_freq, 32'h0000_0000);
    check("end ramp", ramp, 32'h0000_0000);
    check("stage timer", 32'(run2_cnt >= 74 && run2_cnt <= 86), 32'h0000_0001);
    check("skip", 32'(skip_cnt < 3), 32'h0000_0001);
    reset_pulse();
    check("restart stage", stage, 32'h0000_0000);
    wr(pattern_run_pkg::OFF_MODE, 32'h0000_0001);
    keys_to(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_stage(3'h6);
    wait_stage(3'h0);
    cyc(8);
    check("repeat run", run, 32'h0000_0001);
    check("repeat freq", set_freq, 32'(preset[1]));
    keys_to(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(8);
    reset_pulse();
    wr(pattern_run_pkg::OFF_MODE, 32'h0000_0002);
    keys_to(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_stage(3'h2);
    keys_to(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    cyc(8);
    keys_to(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(20);
    check("alarm run", run, 32'h0000_0000);
    keys_to(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    cyc(6);
    keys_to(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    check("alarm resume", run, 32'h0000_0001);
    check("alarm stage", stage, 32'h0000_0002);
    wait_stage(3'h6);
    cyc(DUR * TICKS + 20);
    check("hold run", run, 32'h0000_0001);
    check("hold freq", set_freq, 32'(preset[7]));
    wr(pattern_run_pkg::OFF_FSEL, 32'h0000_0000);
    @(posedge i_clk_sys);
    keys <= 4'h3;
    cyc(20);
    check("source off freq", set_freq, 32'(preset[3]));
    check("source off stage", stage, 32'h0000_0006);
    end_sim();
  end
endmodule : tb_pattern_run_freq_sequencer
`default_nettype wire

/* File: testbench/term_panel_model.sv */
// keypad panel and control terminal model driving the run and step pins
`timescale 1ns/1ps
`default_nettype none
module term_panel_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_run_key,
  input  wire logic       i_back_key,
  input  wire logic       i_stop_key,
  input  wire logic       i_reset_key,
  input  wire logic       i_fault,
  input  wire logic [3:0] i_step_keys,
  output logic            o_forward_run_cmd,
  output logic            o_reverse_run_cmd,
  output logic            o_stop_cmd,
  output logic            o_reset_cmd,
  output logic            o_alarm_stop,
  output logic [3:0]      o_step_sel
);
  initial begin
    {o_forward_run_cmd, o_reverse_run_cmd, o_stop_cmd, o_reset_cmd, o_alarm_stop} = '0;
    o_step_sel = '0;
  end
  // the operator lets go of run while pressing reset, as a maintained switch would
  always @(posedge i_clk_sys) begin
    o_forward_run_cmd <= i_run_key & ~i_reset_key;
    o_reverse_run_cmd <= i_back_key;
    o_stop_cmd        <= i_stop_key | i_reset_key;
    o_reset_cmd       <= i_reset_key;
    o_alarm_stop      <= i_fault;
    o_step_sel        <= i_step_keys;
  end
endmodule : term_panel_model
`default_nettype wire
